// File: hdl/move_ret_defs.vh
`ifndef MOVE_RET_DEFS_VH
`define MOVE_RET_DEFS_VH
// 14-bit instruction encodings, then interrupt-enable, return-length and reset constants.
`define OPC_MOVE_MASK     14'h3f80
`define OPC_MOVE_W_F      14'h0080
`define OPC_LIT_MASK      14'h3f00
`define OPC_LOAD_LIT      14'h3000
`define OPC_RET_LIT       14'h3400
`define OPC_NOP_MASK      14'h3f9f
`define OPC_NOP           14'h0000
`define OPC_RETURN        14'h0008
`define OPC_RETFI         14'h0009
`define INT_ENABLE_BIT    7
`define INT_ENABLE_RESET  1'h0
`define RET_CYCLES        2
`define W_RESET           8'h00
`define PC_RESET          13'h0000
`endif

// File: hdl/return_stack.v
`timescale 1ns/10ps
`include "move_ret_defs.vh"
module return_stack #(
    parameter DEPTH  = 8,
    parameter PTR_W  = 3,
    parameter ADDR_W = 13
) (
    // Clock and reset
    input  wire              core_clk,
    input  wire              rst_n,
    // Push and pop
    input  wire              push,
    input  wire [ADDR_W-1:0] push_addr,
    input  wire              pop,
    output wire [ADDR_W-1:0] top
);
    reg  [ADDR_W-1:0] mem_ff [0:DEPTH-1];
    reg  [PTR_W-1:0]  ptr_ff;
    wire [PTR_W-1:0]  top_idx;
    integer i;

    // The stack is circular: overflow silently overwrites the oldest entry.
    assign top_idx = ptr_ff - {{(PTR_W-1){1'b0}}, 1'b1};
    assign top     = mem_ff[top_idx];

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_ff <= {PTR_W{1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_ff[i] <= {ADDR_W{1'b0}};
            end
        end else if (push) begin
            mem_ff[ptr_ff] <= push_addr;
            ptr_ff         <= ptr_ff + {{(PTR_W-1){1'b0}}, 1'b1};
        end else if (pop) begin
            ptr_ff <= top_idx;
        end
    end
endmodule // return_stack

// File: hdl/move_and_return_instr_exec.v
`timescale 1ns/10ps
`include "move_ret_defs.vh"
module move_and_return_instr_exec #(
    parameter ADDR_W = 13,
    parameter DEPTH  = 8,
    parameter PTR_W  = 3
) (
    // Clock and reset
    input  wire              core_clk,
    input  wire              rst_n,
    // Instruction fetch
    input  wire              instr_valid,
    input  wire [13:0]       instr,
    output wire              instr_ready,
    // Call push from the rest of the core
    input  wire              call_push,
    input  wire [ADDR_W-1:0] call_addr,
    // Interrupt control register bit from the rest of the core
    input  wire              global_interrupt_enable_clear,
    // File register write port
    output reg               file_we_ff,
    output reg  [6:0]        file_addr_ff,
    output reg  [7:0]        file_wdata_ff,
    // Architectural state
    output reg  [7:0]        working_ff,
    output reg  [ADDR_W-1:0] pc_ff,
    output reg               global_interrupt_enable_ff,
    output wire              busy
);
    // One-hot execution states.
    localparam ST_EXEC = 2'b01;
    localparam ST_FLSH = 2'b10;

    // One-hot instruction classes; anything outside this group only advances the PC.
    localparam OP_NONE = 7'h01;
    localparam OP_MOVE = 7'h02;
    localparam OP_LIT  = 7'h04;
    localparam OP_RLIT = 7'h08;
    localparam OP_RINT = 7'h10;
    localparam OP_RSUB = 7'h20;
    localparam OP_IDLE = 7'h40;

    reg  [1:0]        state_ff;
    reg  [1:0]        nxt_state;
    reg  [6:0]        op_class;
    reg  [7:0]        nxt_working;
    reg  [ADDR_W-1:0] nxt_pc;
    reg               nxt_global_interrupt_enable;
    reg               nxt_file_we;
    reg               pop;
    wire [ADDR_W-1:0] return_stack_top;
    wire [ADDR_W-1:0] pc_step;
    wire              take;
    wire              is_move_w_f;
    wire              is_load_lit;
    wire              is_ret_lit;
    wire              is_ret_int;
    wire              is_return;
    wire              is_nop;

    assign is_move_w_f = ((instr & `OPC_MOVE_MASK) == `OPC_MOVE_W_F);
    assign is_load_lit = ((instr & `OPC_LIT_MASK) == `OPC_LOAD_LIT);
    assign is_ret_lit  = ((instr & `OPC_LIT_MASK) == `OPC_RET_LIT);
    assign is_nop      = ((instr & `OPC_NOP_MASK) == `OPC_NOP);
    assign is_return   = (instr == `OPC_RETURN);
    assign is_ret_int  = (instr == `OPC_RETFI);

    // Second cycle of a return is a dead cycle while the new fetch starts.
    assign instr_ready = (state_ff == ST_EXEC);
    assign busy        = (state_ff == ST_FLSH);
    assign take        = instr_valid && instr_ready;
    assign pc_step     = pc_ff + {{(ADDR_W-1){1'b0}}, 1'b1};

    return_stack #(
        .DEPTH  (DEPTH),
        .PTR_W  (PTR_W),
        .ADDR_W (ADDR_W)
    ) u_stack (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .push      (call_push),
        .push_addr (call_addr),
        .pop       (pop),
        .top       (return_stack_top)
    );

    always @* begin
        op_class = OP_NONE;
        if (is_move_w_f) begin
            op_class = OP_MOVE;
        end else if (is_load_lit) begin
            op_class = OP_LIT;
        end else if (is_ret_lit) begin
            op_class = OP_RLIT;
        end else if (is_ret_int) begin
            op_class = OP_RINT;
        end else if (is_return) begin
            op_class = OP_RSUB;
        end else if (is_nop) begin
            op_class = OP_IDLE;
        end
    end

    always @* begin
        nxt_state = state_ff;
        pop       = 1'b0;
        case (state_ff)
            ST_EXEC: begin
                if (take) begin
                    case (op_class)
                        OP_RLIT: begin
                            pop       = 1'b1;
                            nxt_state = ST_FLSH;
                        end
                        OP_RINT: begin
                            pop       = 1'b1;
                            nxt_state = ST_FLSH;
                        end
                        OP_RSUB: begin
                            pop       = 1'b1;
                            nxt_state = ST_FLSH;
                        end
                        default: begin
                            nxt_state = ST_EXEC;
                        end
                    endcase
                end
            end
            ST_FLSH: begin
                nxt_state = ST_EXEC;
            end
            default: begin
                nxt_state = ST_EXEC;
            end
        endcase
    end

    always @* begin
        nxt_working = working_ff;
        if (take) begin
            case (op_class)
                OP_LIT: begin
                    nxt_working = instr[7:0];
                end
                OP_RLIT: begin
                    nxt_working = instr[7:0];
                end
                default: begin
                    nxt_working = working_ff;
                end
            endcase
        end
    end

    always @* begin
        nxt_pc = pc_ff;
        if (take) begin
            case (op_class)
                OP_RLIT: begin
                    nxt_pc = return_stack_top;
                end
                OP_RINT: begin
                    nxt_pc = return_stack_top;
                end
                OP_RSUB: begin
                    nxt_pc = return_stack_top;
                end
                OP_IDLE: begin
                    nxt_pc = pc_step;
                end
                default: begin
                    nxt_pc = pc_step;
                end
            endcase
        end
    end

    // A software clear in the same cycle as an interrupt return loses, so the return
    // always leaves interrupts enabled; a subroutine return never touches the bit.
    always @* begin
        nxt_global_interrupt_enable = global_interrupt_enable_ff;
        if (take && (op_class == OP_RINT)) begin
            nxt_global_interrupt_enable = 1'b1;
        end else if (global_interrupt_enable_clear) begin
            nxt_global_interrupt_enable = 1'b0;
        end
    end

    always @* begin
        nxt_file_we = take && (op_class == OP_MOVE);
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_EXEC;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            working_ff <= `W_RESET;
        end else begin
            working_ff <= nxt_working;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_ff <= `PC_RESET;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            global_interrupt_enable_ff <= `INT_ENABLE_RESET;
        end else begin
            global_interrupt_enable_ff <= nxt_global_interrupt_enable;
        end
    end

    // Address and data keep their last values between writes; only the strobe pulses.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_we_ff    <= 1'b0;
            file_addr_ff  <= 7'h00;
            file_wdata_ff <= 8'h00;
        end else begin
            file_we_ff <= nxt_file_we;
            if (nxt_file_we) begin
                file_addr_ff  <= instr[6:0];
                file_wdata_ff <= working_ff;
            end
        end
    end
endmodule // move_and_return_instr_exec

// File: dv/move_and_return_instr_exec_props.sv
`timescale 1ns/10ps
module move_and_return_instr_exec_props #(parameter ADDR_W = 13) (
    // Clock and reset
    input logic              core_clk,
    input logic              rst_n,
    // Instruction side
    input logic              instr_valid,
    input logic [13:0]       instr,
    input logic              instr_ready,
    input logic              call_push,
    input logic [ADDR_W-1:0] call_addr,
    input logic              global_interrupt_enable_clear,
    // Results
    input logic              file_we_ff,
    input logic [6:0]        file_addr_ff,
    input logic [7:0]        file_wdata_ff,
    input logic [7:0]        working_ff,
    input logic [ADDR_W-1:0] pc_ff,
    input logic              global_interrupt_enable_ff,
    input logic              busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire taken = instr_valid && instr_ready;
    // A return refuses exactly one cycle, then accepts again.
    sequence s_two; !instr_ready && busy ##1 instr_ready; endsequence
    property p_move; taken && instr[13:7] == 7'h01 |=> file_we_ff && instr_ready &&
        file_addr_ff == $past(instr[6:0]) && file_wdata_ff == $past(working_ff); endproperty
    property p_lit; taken && instr[13:8] == 6'h30 |=> working_ff == $past(instr[7:0]) &&
        instr_ready; endproperty
    property p_rfi_two; taken && instr == 14'h0009 |=> s_two; endproperty
    property p_rfi_gie; taken && instr == 14'h0009 |=> global_interrupt_enable_ff; endproperty
    property p_retlit; taken && instr[13:8] == 6'h34 |=> working_ff == $past(instr[7:0]) ##0
        s_two; endproperty
    property p_ret; taken && instr == 14'h0008 && !global_interrupt_enable_clear |=>
        global_interrupt_enable_ff == $past(global_interrupt_enable_ff) ##0 s_two; endproperty
    property p_nop; taken && instr == 14'h0000 |=> pc_ff == $past(pc_ff) + 1'h1 && instr_ready &&
        working_ff == $past(working_ff) && !file_we_ff; endproperty
    a_move: assert property (p_move) else $error("move result wrong");
    a_lit: assert property (p_lit) else $error("literal load wrong");
    a_rfi_two: assert property (p_rfi_two) else $error("interrupt return length");
    a_rfi_gie: assert property (p_rfi_gie) else $error("interrupt enable not set");
    a_retlit: assert property (p_retlit) else $error("literal return wrong");
    a_ret: assert property (p_ret) else $error("subroutine return wrong");
    a_nop: assert property (p_nop) else $error("no-operation changed state");
endmodule // move_and_return_instr_exec_props
bind move_and_return_instr_exec move_and_return_instr_exec_props #(.ADDR_W(ADDR_W)) i_props (.*);

// File: dv/move_and_return_instr_exec_bench.sv
`timescale 1ns/10ps
`include "move_ret_defs.vh"
module move_and_return_instr_exec_bench;
    logic core_clk = 1'h0, rst_n = 1'h0, instr_valid = 1'h0, call_push = 1'h0;
    logic global_interrupt_enable_clear = 1'h0;
    logic [13:0] instr = 14'h0;
    logic [12:0] call_addr = 13'h0, pc_ff;
    logic [7:0]  working_ff, file_wdata_ff;
    logic [6:0]  file_addr_ff;
    logic        instr_ready, file_we_ff, global_interrupt_enable_ff, busy;
    integer      n_mismatch = 0, tests_run = 0;
    move_and_return_instr_exec i_move_and_return_instr_exec (.*);
    always #20 core_clk = ~core_clk;
    task close_out;
        $display("mismatches %0d in %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input ok);
        tests_run++;
        if (!ok) begin
            n_mismatch++;
            $display("unexpected at %0t: wrong result", $time);
        end
    endtask
    // Each driver lowers the other strobe on entry and leaves its own up on return, so
    // no strobe is lowered and raised again within one time step between calls.
    task side(input [12:0] a);
        instr_valid = 1'h0;
        call_push = 1'h1;
        call_addr = a;
        @(posedge core_clk) #1;
    endtask
    // A request held through the refused cycle of a return must be taken exactly once.
    task op(input [13:0] i);
        integer n;
        call_push = 1'h0;
        instr_valid = 1'h1;
        instr = i;
        for (n = 0; n < 4 && instr_ready !== 1'h1; n++) @(posedge core_clk) #1;
        if (n < 4) begin
            @(posedge core_clk) #1;
        end else begin
            chk(1'h0);
            close_out;
        end
    endtask
    task t_lit_move;
        op(`OPC_LOAD_LIT | 14'h00a5);
        chk(working_ff === 8'ha5);
        op(`OPC_MOVE_W_F | 14'h007f);
        chk(file_we_ff === 1'h1 && file_addr_ff === 7'h7f && file_wdata_ff === 8'ha5);
        chk(pc_ff === 13'h0002 && working_ff === 8'ha5);
        $display("move and literal test done");
    endtask
    task t_nop;
        op(`OPC_NOP);
        chk(pc_ff === 13'h0003 && working_ff === 8'ha5 && file_we_ff === 1'h0);
        $display("no-operation test done");
    endtask
    task t_return_with_literal;
        side(13'h1234);
        op(`OPC_RET_LIT | 14'h003c);
        chk(working_ff === 8'h3c && pc_ff === 13'h1234);
        chk(busy === 1'h1 && instr_ready === 1'h0);
        $display("literal return test done");
    endtask
    // Runs after the interrupt return, so an enable bit left at one shows it is untouched.
    task t_return;
        side(13'h0abc);
        side(13'h0def);
        op(`OPC_RETURN);
        chk(pc_ff === 13'h0def && global_interrupt_enable_ff === 1'h1);
        op(`OPC_RETURN);
        chk(pc_ff === 13'h0abc && global_interrupt_enable_ff === 1'h1);
        instr_valid = 1'h0;
        global_interrupt_enable_clear = 1'h1;
        @(posedge core_clk) #1 global_interrupt_enable_clear = 1'h0;
        chk(global_interrupt_enable_ff === 1'h0 && pc_ff === 13'h0abc);
        $display("subroutine return test done");
    endtask
    // The clear is held across the taking edge: the interrupt return must still win.
    task t_return_from_interrupt;
        side(13'h0155);
        global_interrupt_enable_clear = 1'h1;
        op(`OPC_RETFI);
        global_interrupt_enable_clear = 1'h0;
        chk(pc_ff === 13'h0155 && global_interrupt_enable_ff === 1'h1);
        chk(instr_ready === 1'h0);
        op(`OPC_NOP);
        chk(pc_ff === 13'h0156);
        $display("interrupt return test done");
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        #1 rst_n = 1'h1;
        t_lit_move;
        t_nop;
        t_return_with_literal;
        t_return_from_interrupt;
        t_return;
        close_out;
    end
endmodule // move_and_return_instr_exec_bench
